//--- inc/xls_pkg.sv
// Shared constants, codes and state types for the lane sync and deskew block.
package xls_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int LANES      = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int ENTRY_W    = 11;
  localparam int E_CTL      = 8;
  localparam int E_ERR      = 9;
  localparam int E_DISP     = 10;
  localparam logic [1:0] GOOD_LAST = 2'h3;

  // ****************************************************************
  // Code values
  // ****************************************************************
  localparam logic [7:0] CODE_ALIGN = 8'h7C;
  localparam logic [7:0] CODE_SYNC  = 8'hBC;
  localparam logic [7:0] CODE_TERM  = 8'hFD;
  localparam logic [7:0] CODE_ERROR = 8'hFE;
  localparam logic [7:0] CODE_IDLE  = 8'h07;
  localparam logic [31:0] LF_DATA   = 32'h0100_009C;
  localparam logic [3:0]  LF_CTL    = 4'h1;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h04;
  localparam int ST_LOCK_LSB   = 0;
  localparam int ST_DESKEW_BIT = 4;
  localparam int ST_LF_BIT     = 5;
  localparam int CT_FORCE_BIT  = 0;
  localparam int CT_EOP_BIT    = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [2:0] {
    state_a, acq_first_state, acq_second_state, acq_third_state,
    sync_state, miss_first_state, miss_second_state, miss_third_state
  } xls_lane_state_type;

  typedef enum logic [2:0] {
    unaligned_state, detect_first_state, detect_second_state,
    detect_third_state, aligned_state, fail_first_state,
    fail_second_state, fail_third_state
  } xls_col_state_type;

  // True when an entry carries the given control code.
  function automatic logic xls_is_code(input logic [ENTRY_W-1:0] e,
                                       input logic [7:0] code);
    return e[E_CTL] && (e[7:0] == code);
  endfunction : xls_is_code

endpackage : xls_pkg

//--- rtl/xls_deskew_top.sv
// Lane sync, column deskew, fault insertion and APB status for one channel.
`timescale 1ns/1ps
module xls_deskew_top
#(
  parameter int DEPTH = xls_pkg::FIFO_DEPTH
)
(
  input  wire logic                       clock,
  input  wire logic                       nrst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [xls_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [31:0]                lane_data,
  input  wire logic [xls_pkg::LANES-1:0]  lane_ctl,
  input  wire logic [xls_pkg::LANES-1:0]  lane_code_err,
  input  wire logic [xls_pkg::LANES-1:0]  lane_disp_err,
  input  wire logic [xls_pkg::LANES-1:0]  lane_comma,
  output logic [xls_pkg::LANES-1:0]       lane_realign_en,
  output logic [xls_pkg::LANES-1:0]       lane_locked_flag,
  output logic                            lanes_deskewed_flag,
  output logic                            local_fault_latched,
  output logic [31:0]                     rxd,
  output logic [xls_pkg::LANES-1:0]       rxc
);
  import xls_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

  // ****************************************************************
  // Lane synchronisation
  // ****************************************************************
  xls_lane_state_type lane_state [LANES];
  logic [LANES-1:0]   lane_err;
  logic [LANES-1:0]   lane_state_a;

  assign lane_err = lane_code_err | lane_disp_err;

  // Each lane is its own instance of this module, all sharing the one nrst reset.
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    xls_lane_sync u_sync
    (
      .clock       (clock),
      .nrst        (nrst),
      .comma_found (lane_comma[i]),
      .code_err    (lane_err[i]),
      .state_reg   (lane_state[i]),
      .locked_reg  (lane_locked_flag[i]),
      .realign_reg (lane_realign_en[i])
    );
    assign lane_state_a[i] = lane_state[i] == state_a;
  end

  // ****************************************************************
  // Receive FIFOs
  // ****************************************************************
  // Every lane writes one code per clock; only the read side moves
  // independently, which is what absorbs the skew between lanes.
  logic [ENTRY_W-1:0] fifo_mem [LANES][DEPTH];
  logic [AW:0]        wr_ptr_reg;
  logic [AW:0]        rd_ptr_reg [LANES];
  logic [ENTRY_W-1:0] head [LANES];
  logic [LANES-1:0]   nonempty;
  logic [LANES-1:0]   full;
  logic [LANES-1:0]   head_a;
  logic [LANES-1:0]   pop;
  logic               col_pop;
  logic               col_any_a;
  logic               col_all_a;
  xls_col_state_type  col_state_reg;
  xls_col_state_type  col_state_next;

  always_ff @(posedge clock)
  begin
    for (int i = 0; i < LANES; i++)
      fifo_mem[i][wr_ptr_reg[AW-1:0]] <= {lane_disp_err[i], lane_err[i],
                                          lane_ctl[i], lane_data[8*i +: 8]};
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      wr_ptr_reg <= '0;
    else
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
  end

  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      head[i]     = fifo_mem[i][rd_ptr_reg[i][AW-1:0]];
      nonempty[i] = wr_ptr_reg != rd_ptr_reg[i];
      full[i]     = (wr_ptr_reg - rd_ptr_reg[i]) == DEPTH_W;
      head_a[i]   = nonempty[i] && xls_is_code(head[i], CODE_ALIGN);
    end
  end

  // While unaligned a lane parks on its /A/ until the others catch up;
  // a full lane is drained anyway so a lone /A/ cannot wedge it.
  always_comb
  begin
    if (col_state_reg == unaligned_state && !(&head_a))
      pop = (nonempty & ~head_a) | full;
    else
      pop = {LANES{&nonempty}};
  end

  assign col_pop   = &pop;
  assign col_any_a = col_pop && (|head_a);
  assign col_all_a = col_pop && (&head_a);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      for (int i = 0; i < LANES; i++)
        rd_ptr_reg[i] <= '0;
    else
      for (int i = 0; i < LANES; i++)
        if (pop[i])
          rd_ptr_reg[i] <= rd_ptr_reg[i] + 1'b1;
  end

  // ****************************************************************
  // Column deskew machine
  // ****************************************************************
  // Any column holding an /A/ is taken as a gap column; a partial one is
  // the deskew error.
  always_comb
  begin
    col_state_next = col_state_reg;
    unique case (col_state_reg)
      unaligned_state:
        if (col_all_a) col_state_next = detect_first_state;
      detect_first_state, detect_second_state, detect_third_state:
        if (col_all_a)
          col_state_next = xls_col_state_type'(col_state_reg + 3'h1);
        else if (col_any_a)
          col_state_next = unaligned_state;
      aligned_state:
        if (col_any_a && !col_all_a)
          col_state_next = fail_first_state;
      fail_first_state, fail_second_state, fail_third_state:
        if (col_all_a)
          col_state_next = aligned_state;
        else if (col_any_a)
          col_state_next = (col_state_reg == fail_third_state)
                         ? unaligned_state
                         : xls_col_state_type'(col_state_reg + 3'h1);
    endcase
    if (|lane_state_a)
      col_state_next = unaligned_state;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      col_state_reg       <= unaligned_state;
      lanes_deskewed_flag <= 1'b0;
    end
    else
    begin
      col_state_reg       <= col_state_next;
      lanes_deskewed_flag <= col_state_next >= aligned_state;
    end
  end

  // ****************************************************************
  // Receive output
  // ****************************************************************
  // One column is held back so that a disparity error caught by the end
  // code can still poison the data before it.
  logic [ENTRY_W-1:0] hold_reg [LANES];
  logic               eop_bad;
  logic               fault_now;
  logic [31:0]        ctrl_reg;
  logic [31:0]        rxd_next;
  logic [LANES-1:0]   rxc_next;

  always_comb
  begin
    eop_bad = 1'b0;
    for (int i = 0; i < LANES; i++)
      if (col_pop && head[i][E_DISP] && head[i][E_CTL] &&
          (head[i][7:0] inside {CODE_ALIGN, CODE_SYNC, CODE_TERM}))
        eop_bad = ctrl_reg[CT_EOP_BIT];
  end

  assign fault_now = !(&lane_locked_flag) || !lanes_deskewed_flag;

  always_comb
  begin
    rxd_next = {LANES{CODE_IDLE}};
    rxc_next = '1;
    if (fault_now || ctrl_reg[CT_FORCE_BIT])
    begin
      rxd_next = LF_DATA;
      rxc_next = LF_CTL;
    end
    else if (col_pop)
      for (int i = 0; i < LANES; i++)
      begin
        // Sequence sets and remote faults pass here untouched.
        rxd_next[8*i +: 8] = hold_reg[i][7:0];
        rxc_next[i]        = hold_reg[i][E_CTL];
        if (hold_reg[i][E_ERR] || (eop_bad && !hold_reg[i][E_CTL]))
        begin
          rxd_next[8*i +: 8] = CODE_ERROR;
          rxc_next[i]        = 1'b1;
        end
      end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rxd <= LF_DATA;
      rxc <= LF_CTL;
      for (int i = 0; i < LANES; i++)
        hold_reg[i] <= '0;
    end
    else
    begin
      rxd <= rxd_next;
      rxc <= rxc_next;
      if (col_pop)
        for (int i = 0; i < LANES; i++)
          hold_reg[i] <= head[i];
    end
  end

  // ****************************************************************
  // APB register slave
  // ****************************************************************
  logic        apb_access;
  logic        apb_done;
  logic        hit_status;
  logic        hit_control;
  logic [31:0] status_word;

  assign apb_access  = psel && penable && !pready;
  assign apb_done    = psel && penable && pready;
  assign hit_status  = paddr == OFS_STATUS;
  assign hit_control = paddr == OFS_CONTROL;

  always_comb
  begin
    status_word = '0;
    status_word[ST_LOCK_LSB +: LANES] = lane_locked_flag;
    status_word[ST_DESKEW_BIT]        = lanes_deskewed_flag;
    status_word[ST_LF_BIT]            = local_fault_latched;
  end

  // One wait state: data and error are loaded on the first access edge,
  // so they stand stable at the completing edge.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_access;
      pslverr <= apb_access && !hit_status && !hit_control;
      if (apb_access && !pwrite)
        prdata <= hit_status ? status_word
                : hit_control ? ctrl_reg : '0;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ctrl_reg <= CTRL_RESET;
    else if (apb_done && pwrite && hit_control)
      ctrl_reg <= pwdata;
  end

  // Read of status clears the latch, but a fault in that cycle wins.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      local_fault_latched <= 1'b0;
    else if (fault_now)
      local_fault_latched <= 1'b1;
    else if (apb_done && !pwrite && hit_status)
      local_fault_latched <= 1'b0;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_unlock_local_fault: assert property (
    !(&lane_locked_flag) |=> rxd == LF_DATA && rxc == LF_CTL)
    else $error("unlocked lane did not give local fault");
  chk_deskew_local_fault: assert property (
    !lanes_deskewed_flag |=> rxd == LF_DATA && rxc == LF_CTL)
    else $error("unaligned column did not give local fault");
  chk_state_a_unaligns: assert property (
    |lane_state_a |=> col_state_reg == unaligned_state)
    else $error("column not forced unaligned by state_a lane");
  chk_detect_advance: assert property (
    col_state_reg == detect_third_state && col_all_a && !(|lane_state_a)
    |=> col_state_reg == aligned_state && lanes_deskewed_flag)
    else $error("third detect did not reach aligned");
  chk_detect_partial: assert property (
    col_state_reg > unaligned_state && col_state_reg < aligned_state
    && col_any_a && !col_all_a |=> col_state_reg == unaligned_state)
    else $error("partial column in detect did not unaligned_state");
  chk_align_fail_flag: assert property (
    col_state_reg == aligned_state && col_any_a && !col_all_a
    && !(|lane_state_a) |=> col_state_reg == fail_first_state
    && lanes_deskewed_flag)
    else $error("deskew error in aligned did not enter fail");
  chk_fail_recover: assert property (
    col_state_reg >= fail_first_state && col_all_a && !(|lane_state_a)
    |=> col_state_reg == aligned_state)
    else $error("complete column did not restore aligned");
  chk_fault_latch_set: assert property (
    fault_now ##1 !(apb_done && hit_status) |-> local_fault_latched [*2])
    else $error("local fault latch not set");

endmodule : xls_deskew_top

//--- rtl/xls_lane_sync.sv
// Code-group synchronisation machine for one serial lane.
`timescale 1ns/1ps
module xls_lane_sync
(
  input  wire logic                       clock,
  input  wire logic                       nrst,
  input  wire logic                       comma_found,
  input  wire logic                       code_err,
  output xls_pkg::xls_lane_state_type     state_reg,
  output logic                            locked_reg,
  output logic                            realign_reg
);
  import xls_pkg::*;

  xls_lane_state_type state_next;
  logic [1:0]         good_cnt_reg;
  logic               good_run;

  assign good_run = !code_err && (good_cnt_reg == GOOD_LAST);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      state_a:
        if (comma_found) state_next = acq_first_state;
      acq_first_state, acq_second_state, acq_third_state:
        if (code_err) state_next = state_a;
        else if (comma_found)
          state_next = (state_reg == acq_third_state) ? sync_state
                     : xls_lane_state_type'(state_reg + 3'h1);
      sync_state:
        if (code_err) state_next = miss_first_state;
      miss_first_state:
        if (code_err) state_next = miss_second_state;
        else if (good_run) state_next = sync_state;
      miss_second_state:
        if (code_err) state_next = miss_third_state;
        else if (good_run) state_next = miss_first_state;
      miss_third_state:
        if (code_err) state_next = state_a;
        else if (good_run) state_next = miss_first_state;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg   <= state_a;
      locked_reg  <= 1'b0;
      realign_reg <= 1'b1;
    end
    else
    begin
      state_reg   <= state_next;
      locked_reg  <= state_next >= sync_state;
      realign_reg <= state_next == state_a;
    end
  end

  // The run counter restarts on any state change, so each miss state
  // counts its own four good codes from entry.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      good_cnt_reg <= 2'h0;
    else if (code_err || state_next != state_reg)
      good_cnt_reg <= 2'h0;
    else
      good_cnt_reg <= good_cnt_reg + 2'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_miss_first_state_entered;
    $rose(state_reg == miss_first_state);
  endsequence
  sequence s_four_good;
    (!code_err)[*4];
  endsequence

  chk_miss_recover_sync: assert property (
    s_miss_first_state_entered ##0 s_four_good |=> state_reg == sync_state)
    else $error("lane did not return to sync after four good codes");
  chk_acq_error_drop: assert property (
    (state_reg inside {acq_first_state, acq_second_state,
                       acq_third_state}) && code_err |=> state_reg == state_a)
    else $error("acquisition error did not drop the lane");
  chk_lock_flag_zero: assert property (
    state_reg < sync_state |-> !locked_reg && (realign_reg ==
                                              (state_reg == state_a)))
    else $error("lock flag or realign wrong while unsynchronised");
  chk_miss_third_state_drop: assert property (
    state_reg == miss_third_state && code_err |=> state_reg == state_a)
    else $error("third miss error did not drop the lane");

endmodule : xls_lane_sync

//--- sim/xls_deskew_top_tb.sv
// Self-checking bench for the lane sync and column deskew block.
`timescale 1ns/1ps
module xls_deskew_top_tb;
  import xls_pkg::*;

  logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
  logic        lanes_deskewed_flag, local_fault_latched, se, found;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, lane_data, rxd, rand_data, rd;
  logic [3:0]  lane_ctl, lane_code_err, lane_disp_err, lane_comma, rxc;
  logic [3:0]  lane_realign_en, lane_locked_flag, err_mask, disp_mask;
  logic [3:0]  drop_a;
  int          error_cnt, n_compared;

  xls_deskew_top #(.DEPTH(FIFO_DEPTH)) DUT (.clock(clock), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_data(lane_data), .lane_ctl(lane_ctl),
    .lane_code_err(lane_code_err), .lane_disp_err(lane_disp_err),
    .lane_comma(lane_comma), .lane_realign_en(lane_realign_en),
    .lane_locked_flag(lane_locked_flag),
    .lanes_deskewed_flag(lanes_deskewed_flag),
    .local_fault_latched(local_fault_latched), .rxd(rxd), .rxc(rxc));

  xls_lane_src far_end (.clock(clock), .nrst(nrst), .rand_data(rand_data),
    .err_mask(err_mask), .disp_mask(disp_mask), .drop_a(drop_a),
    .lane_data(lane_data), .lane_ctl(lane_ctl),
    .lane_code_err(lane_code_err), .lane_disp_err(lane_disp_err),
    .lane_comma(lane_comma));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  function automatic logic [3:0] sig(input logic which);
    return which ? {3'h0, lanes_deskewed_flag} : lane_locked_flag;
  endfunction : sig

  function automatic logic [31:0] status_exp(input logic [3:0] lock,
                                             input logic desk,
                                             input logic lf);
    return (32'(lf) << ST_LF_BIT) | (32'(desk) << ST_DESKEW_BIT) |
           (32'(lock) << ST_LOCK_LSB);
  endfunction : status_exp

  // A wait that runs out is counted as a mismatch and ends the run.
  task automatic wait_sig(input logic which, input logic [3:0] exp,
                          input int lim);
    int n;
    for (n = 0; n < lim && sig(which) !== exp; n++)
      @(posedge clock);
    chk({28'h0, sig(which)}, {28'h0, exp});
    if (sig(which) !== exp)
      give_verdict();
  endtask : wait_sig

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clock);
    chk({31'h0, pready}, 32'h1);
    if (pready !== 1'b1)
      give_verdict();
    rd      = prdata;
    se      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic hit(input logic [3:0] m, input logic [3:0] dm,
                     input int n);
    @(posedge clock);
    err_mask  <= m;
    disp_mask <= dm;
    repeat (n) @(posedge clock);
    err_mask  <= 4'h0;
    disp_mask <= 4'h0;
  endtask : hit

  // Called just after an edge, so calls in a row cover exactly n edges
  // each and a window of sixteen holds exactly one gap column.
  task automatic drop(input logic [3:0] m, input int n);
    drop_a <= m;
    repeat (n) @(posedge clock);
  endtask : drop

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; rand_data = 32'h0; err_mask = 4'h0;
    disp_mask = 4'h0; drop_a = 4'h0; error_cnt = 0; n_compared = 0;
    void'($urandom(89083));
    fork
      forever
      begin
        @(posedge clock);
        rand_data <= $urandom;
      end
    join_none
    repeat (12) @(posedge clock);
    chk(rxd, LF_DATA);
    chk({28'h0, rxc}, {28'h0, LF_CTL});
    chk({28'h0, lane_realign_en}, 32'hF);
    chk({28'h0, lane_locked_flag}, 32'h0);
    chk({31'h0, lanes_deskewed_flag}, 32'h0);
    nrst <= 1'b1;
    wait_sig(1'b0, 4'hF, 200);
    chk({28'h0, lane_realign_en}, 32'h0);
    wait_sig(1'b1, 4'h1, 400);
    repeat (4) @(posedge clock);
    chk({31'h0, rxd !== LF_DATA}, 32'h1);
    chk({31'h0, local_fault_latched}, 32'h1);
    $display("test sync done");

    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, status_exp(4'hF, 1'b1, 1'b1));
    apb(1'b1, 8'h0C, 32'h1);
    chk({31'h0, se}, 32'h1);
    apb(1'b0, OFS_CONTROL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b1, OFS_CONTROL, CTRL_RESET | 32'h1);
    repeat (3) @(posedge clock);
    chk(rxd, LF_DATA);
    apb(1'b1, OFS_CONTROL, CTRL_RESET);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, status_exp(4'hF, 1'b1, 1'b0));
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, status_exp(4'hF, 1'b1, 1'b0));
    chk({31'h0, local_fault_latched}, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk({se, rd[30:0]}, 32'h8000_0000);
    $display("test registers done");

    hit(4'h2, 4'h0, 3);
    repeat (2) @(posedge clock);
    chk({28'h0, lane_locked_flag}, 32'hF);
    repeat (10) @(posedge clock);
    hit(4'h0, 4'h2, 4);
    @(posedge clock);
    chk({28'h0, lane_locked_flag}, 32'hD);
    chk({28'h0, lane_realign_en}, 32'h2);
    repeat (2) @(posedge clock);
    chk({31'h0, lanes_deskewed_flag}, 32'h0);
    chk(rxd, LF_DATA);
    wait_sig(1'b1, 4'h1, 400);
    $display("test miss done");

    found = 1'b0;
    hit(4'h4, 4'h0, 1);
    repeat (12)
    begin
      @(posedge clock);
      if (rxd[23:16] === CODE_ERROR && rxc[2] === 1'b1)
        found = 1'b1;
    end
    chk({31'h0, found}, 32'h1);
    $display("test error byte done");

    found = 1'b0;
    for (int n = 0; n < 20 && !found; n++)
    begin
      @(posedge clock);
      found = lane_ctl[0] === 1'b1 && lane_data[7:0] === CODE_ALIGN;
    end
    repeat (14) @(posedge clock);
    hit(4'h0, 4'h1, 1);
    found = 1'b0;
    repeat (12)
    begin
      @(posedge clock);
      if (rxd === 32'hFEFE_FEFE && rxc === 4'hF)
        found = 1'b1;
    end
    chk({31'h0, found}, 32'h1);
    $display("test end of packet done");

    repeat (20)
    begin
      hit(4'($urandom), 4'($urandom), 1 + $urandom % 5);
      repeat ($urandom % 20) @(posedge clock);
    end
    wait_sig(1'b0, 4'hF, 400);
    wait_sig(1'b1, 4'h1, 400);
    $display("test random done");

    drop(4'h8, 16);
    drop(4'h0, 32);
    drop(4'h8, 48);
    drop(4'h0, 16);
    drop(4'h8, 16);
    drop(4'h0, 16);
    chk({31'h0, lanes_deskewed_flag}, 32'h1);
    drop(4'h8, 64);
    drop(4'h0, 16);
    chk({31'h0, lanes_deskewed_flag}, 32'h0);
    drop(4'h0, 16);
    drop(4'h8, 16);
    drop(4'h0, 16);
    chk({31'h0, lanes_deskewed_flag}, 32'h0);
    wait_sig(1'b1, 4'h1, 400);
    $display("test deskew done");
    give_verdict();
  end

endmodule : xls_deskew_top_tb

//--- sim/xls_lane_src.sv
// Far-end lane source: four skewed lanes carrying /A/, /K/ and data.
`timescale 1ns/1ps
module xls_lane_src
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [31:0] rand_data,
  input  wire logic [3:0]  err_mask,
  input  wire logic [3:0]  disp_mask,
  input  wire logic [3:0]  drop_a,
  output logic [31:0]      lane_data,
  output logic [3:0]       lane_ctl,
  output logic [3:0]       lane_code_err,
  output logic [3:0]       lane_disp_err,
  output logic [3:0]       lane_comma
);
  import xls_pkg::*;

  logic [3:0] pos_reg;
  logic [8:0] hist_reg [4][4];

  // ****************************************************************
  // Column pattern
  // ****************************************************************
  // Every sixteenth column is a gap of /A/ then three /K/ columns.
  function automatic logic [8:0] fresh(input int l);
    if (pos_reg == 4'h0)
      return drop_a[l] ? {1'b1, CODE_SYNC} : {1'b1, CODE_ALIGN};
    if (pos_reg < 4'h4)
      return {1'b1, CODE_SYNC};
    return {1'b0, rand_data[8*l +: 8]};
  endfunction : fresh

  // Lane l leaves through l extra stages, so the lanes arrive skewed.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pos_reg  <= 4'h0;
      hist_reg <= '{default: {1'b1, CODE_IDLE}};
    end
    else
    begin
      pos_reg <= pos_reg + 4'h1;
      for (int l = 0; l < 4; l++)
      begin
        hist_reg[l][0] <= fresh(l);
        for (int d = 1; d < 4; d++)
          hist_reg[l][d] <= hist_reg[l][d-1];
      end
    end
  end

  always_comb
  begin
    for (int l = 0; l < 4; l++)
    begin
      lane_data[8*l +: 8] = hist_reg[l][l][7:0];
      lane_ctl[l]         = hist_reg[l][l][8];
      lane_comma[l]       = hist_reg[l][l] == {1'b1, CODE_SYNC} &&
                            !err_mask[l] && !disp_mask[l];
    end
  end

  assign lane_code_err = err_mask;
  assign lane_disp_err = disp_mask;

endmodule : xls_lane_src
